// File: core/lrr_pkg.sv
// package: constants and carrier types for the literal-return/rotate unit
package lrr_pkg;
    // ------------------------------------------------------------
    // widths and encodings
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int PC_W = 15;
    localparam int MSB_BIT = 7;
    localparam logic DEST_ACC = 1'h0;
    localparam logic DEST_FILE = 1'h1;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic CARRY_RESET = 1'h0;
    localparam logic [14:0] PC_RESET = 15'h0000;
    localparam logic [6:0] ADDR_RESET = 7'h00;
    localparam int RET_CYCLES = 2;

    typedef enum logic [1:0] {
        LRR_OP_NONE = 2'b00,
        LRR_OP_RET_LIT = 2'b01,
        LRR_OP_ROT_LEFT = 2'b10
    } lrr_op_t;

    // one instruction as issued by the decoder
    typedef struct packed {
        lrr_op_t op;
        logic [7:0] literal;
        logic [6:0] file_addr;
        logic dest;
    } lrr_instr_t;

    // write-back towards the data memory
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } lrr_file_wr_t;
endpackage : lrr_pkg

// File: core/lrr_exec.sv
// module: execution of return_with_literal and rotate_left_through_carry
// ------------------------------------------------------------
// Notes on behaviour
// - return_with_literal loads its 8-bit literal into the accumulator.
// - return_with_literal pops the stack, pc takes stack_top_entry.
// - return_with_literal is one word, two cycles, and keeps all flags.
// - rotate_left_through_carry shifts left, carry in at bit 0, out at 7.
// - for rotate, destination 0 writes the accumulator, 1 writes the file register.
// ------------------------------------------------------------
module lrr_exec #(
    // widths; data and file address held to the carrier structs, PC_W only checked to be at least 1
    parameter int DATA_W = lrr_pkg::DATA_W,
    parameter int ADDR_W = lrr_pkg::ADDR_W,
    parameter int PC_W = lrr_pkg::PC_W,
    // cycles taken by return_with_literal
    parameter int RET_CYCLES = lrr_pkg::RET_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // instruction issue, valid while ready
    input wire lrr_pkg::lrr_instr_t instr,
    input wire logic instr_valid,
    output logic instr_ready,
    // data memory operand port, read data combinational for addr
    output logic [ADDR_W-1:0] file_raddr,
    input wire logic [DATA_W-1:0] file_rdata,
    output lrr_pkg::lrr_file_wr_t file_wr,
    // return stack
    input wire logic [PC_W-1:0] stack_top_entry,
    output logic stack_pop,
    // program counter load
    output logic pc_load,
    output logic [PC_W-1:0] pc_value,
    // accumulator and carry
    output logic [DATA_W-1:0] acc,
    output logic carry
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        LRR_ST_IDLE = 1'b0,
        LRR_ST_RET2 = 1'b1
    } lrr_state_t;

    lrr_state_t state_q, state_d;
    logic [DATA_W-1:0] acc_q, acc_d;
    logic carry_q, carry_d;
    logic pop_q, pop_d;
    logic pc_load_q, pc_load_d;
    logic [PC_W-1:0] pc_q, pc_d;
    lrr_pkg::lrr_file_wr_t wr_q, wr_d;
    logic ready_q, ready_d;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // idle plus one wait state
    localparam int RET_STATES = 2;

    if (DATA_W != lrr_pkg::DATA_W) begin : g_bad_data_w
        $error("data width must match the instruction literal");
    end
    if (DATA_W != lrr_pkg::MSB_BIT + 1) begin : g_bad_msb
        $error("rotate needs the carry-out bit at the top of the data");
    end
    if (ADDR_W != lrr_pkg::ADDR_W) begin : g_bad_addr_w
        $error("file address width must match the instruction field");
    end
    if (PC_W < 1) begin : g_bad_pc_w
        $error("program counter needs at least one bit");
    end
    if (RET_CYCLES != RET_STATES) begin : g_bad_ret
        $error("return state machine serves only two cycles");
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic take = instr_valid && ready_q;
    wire logic is_ret = take && (instr.op == lrr_pkg::LRR_OP_RET_LIT);
    wire logic is_rot = take && (instr.op == lrr_pkg::LRR_OP_ROT_LEFT);
    wire logic [DATA_W-1:0] rot_val = {file_rdata[lrr_pkg::MSB_BIT - 1:0],
                                carry_q};
    wire logic rot_cout = file_rdata[lrr_pkg::MSB_BIT];
    wire logic to_file = instr.dest == lrr_pkg::DEST_FILE;

    assign file_raddr = instr.file_addr;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        acc_d = acc_q;
        carry_d = carry_q;
        pop_d = 1'b0;
        pc_load_d = 1'b0;
        pc_d = pc_q;
        wr_d = '{we: 1'b0, addr: wr_q.addr, data: wr_q.data};
        ready_d = ready_q;
        case (state_q)
            LRR_ST_IDLE: begin
                if (is_ret) begin
                    acc_d = instr.literal;
                    pop_d = 1'b1;
                    pc_load_d = 1'b1;
                    pc_d = stack_top_entry;
                    ready_d = 1'b0;
                    state_d = LRR_ST_RET2;
                end else if (is_rot) begin
                    carry_d = rot_cout;
                    if (to_file) begin
                        wr_d = '{we: 1'b1, addr: instr.file_addr,
                                 data: rot_val};
                    end else begin
                        acc_d = rot_val;
                    end
                end
            end
            LRR_ST_RET2: begin
                ready_d = 1'b1;
                state_d = LRR_ST_IDLE;
            end
            default: begin
                state_d = LRR_ST_IDLE;
                ready_d = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_q <= LRR_ST_IDLE;
            acc_q <= lrr_pkg::ACC_RESET;
            carry_q <= lrr_pkg::CARRY_RESET;
            pop_q <= 1'b0;
            pc_load_q <= 1'b0;
            pc_q <= PC_W'(lrr_pkg::PC_RESET);
            wr_q <= '{we: 1'b0, addr: lrr_pkg::ADDR_RESET,
                      data: lrr_pkg::ACC_RESET};
            ready_q <= 1'b1;
        end else begin
            state_q <= state_d;
            acc_q <= acc_d;
            carry_q <= carry_d;
            pop_q <= pop_d;
            pc_load_q <= pc_load_d;
            pc_q <= pc_d;
            wr_q <= wr_d;
            ready_q <= ready_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign instr_ready = ready_q;
    assign acc = acc_q;
    assign carry = carry_q;
    assign stack_pop = pop_q;
    assign pc_load = pc_load_q;
    assign pc_value = pc_q;
    assign file_wr = wr_q;

    // ------------------------------------------------------------
    // return checks
    // ------------------------------------------------------------
    ret_acc_load_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        is_ret |=> acc == $past(instr.literal))
        else $error("literal not loaded into accumulator");
    ret_pc_pop_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        is_ret |=> stack_pop && pc_load
            && pc_value == $past(stack_top_entry))
        else $error("return did not pop stack into pc");
    ret_pulse_once_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        is_ret |=> ##1 !stack_pop && !pc_load)
        else $error("return pulses longer than one cycle");
    pc_hold_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        !is_ret |=> !stack_pop && !pc_load
            && $stable(pc_value))
        else $error("stack or pc touched without a return");
    ret_two_cycle_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        is_ret |=> !instr_ready ##1 instr_ready)
        else $error("return not two cycles");
    ret_flags_kept_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        is_ret |=> $stable(carry))
        else $error("return changed carry");
    ret_no_write_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        is_ret |=> !file_wr.we)
        else $error("return wrote the file register");

    // ------------------------------------------------------------
    // rotate checks
    // ------------------------------------------------------------
    rot_value_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        is_rot && !to_file |=>
            acc == {$past(file_rdata[6:0]), $past(carry)})
        else $error("rotate result wrong");
    rot_file_data_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        is_rot && to_file |=>
            file_wr.data == {$past(file_rdata[6:0]), $past(carry)})
        else $error("rotate file data wrong");
    rot_carry_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        is_rot |=> carry == $past(file_rdata[7]))
        else $error("rotate carry wrong");
    rot_file_dest_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        is_rot && to_file |=> file_wr.we && $stable(acc)
            && file_wr.addr == $past(instr.file_addr))
        else $error("rotate file write wrong");
    rot_acc_dest_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        is_rot && !to_file |=> !file_wr.we)
        else $error("rotate wrote file for accumulator dest");
    rot_one_cycle_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        is_rot |=> instr_ready && !stack_pop)
        else $error("rotate not single cycle");
    idle_quiet_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        !is_ret && !is_rot |=> $stable(acc) && $stable(carry)
            && !file_wr.we)
        else $error("state changed with no instruction taken");
endmodule : lrr_exec

// File: tb/lrr_exec_tb_top.sv
// testbench: random and corner-case runs of the literal-return/rotate unit
module lrr_exec_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic ref_clk = 1'h0;
    logic resetn = 1'h0;
    logic instr_valid = 1'h0;
    logic [7:0] file_rdata = 8'h00;
    logic [14:0] stack_top_entry = 15'h0000;
    lrr_pkg::lrr_instr_t instr = '0;
    logic instr_ready, stack_pop, pc_load, carry;
    logic [6:0] file_raddr;
    logic [14:0] pc_value;
    logic [7:0] acc, e_acc;
    logic e_c;
    lrr_pkg::lrr_file_wr_t file_wr;
    logic [31:0] seed = 32'hF07F;
    logic [31:0] v;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    lrr_exec lrr_exec_i (.ref_clk(ref_clk), .resetn(resetn), .instr(instr),
        .instr_valid(instr_valid), .instr_ready(instr_ready),
        .file_raddr(file_raddr), .file_rdata(file_rdata), .file_wr(file_wr),
        .stack_top_entry(stack_top_entry), .stack_pop(stack_pop),
        .pc_load(pc_load), .pc_value(pc_value), .acc(acc), .carry(carry));
    // ------------------------------------------------------------
    // clock, timeout, helpers
    // ------------------------------------------------------------
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors++;
            end_of_test();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [8:0] rot_ref(input logic [7:0] f, input logic c);
        return {f, c};
    endfunction : rot_ref
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic put(input lrr_pkg::lrr_op_t op, input logic [7:0] k,
        input logic [6:0] a, input logic d, input logic [7:0] f);
        instr = '{op, k, a, d};
        instr_valid = 1'h1;
        file_rdata = f;
        #1 chk(file_raddr, a);
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : put
    task automatic ret(input logic [7:0] k, input logic [14:0] top);
        stack_top_entry = top;
        put(lrr_pkg::LRR_OP_RET_LIT, k, 7'h00, 1'h0, 8'h00);
        chk(acc, k);
        chk({stack_pop, pc_load, pc_value}, {2'h3, top});
        chk({instr_ready, carry}, {1'h0, e_c});
        e_acc = k;
        put(lrr_pkg::LRR_OP_ROT_LEFT, 8'h00, 7'h05, 1'h0, ~k);
        chk({acc, carry, file_wr.we}, {e_acc, e_c, 1'h0});
        chk({stack_pop, pc_load, instr_ready}, 3'h1);
        $display("test return done k=%h", k);
    endtask : ret
    task automatic rl(input logic [6:0] a, input logic d, input logic [7:0] f);
        logic [7:0] r;
        logic co;
        {co, r} = rot_ref(f, e_c);
        put(lrr_pkg::LRR_OP_ROT_LEFT, 8'h00, a, d, f);
        e_c = co;
        if (d == lrr_pkg::DEST_ACC) e_acc = r;
        chk(carry, e_c);
        chk(acc, e_acc);
        chk(file_wr.we, d);
        if (d) chk({file_wr.addr, file_wr.data}, {a, r});
        chk({stack_pop, pc_load, instr_ready}, 3'h1);
        $display("test rotate done f=%h d=%h", f, d);
    endtask : rl
    task automatic idle();
        logic [12:0] g;
        put(lrr_pkg::LRR_OP_NONE, 8'h5A, 7'h2A, 1'h1, 8'hFF);
        g = {acc, carry, file_wr.we, stack_pop, pc_load, instr_ready};
        chk(g, {e_acc, e_c, 4'h1});
        instr.op = lrr_pkg::LRR_OP_ROT_LEFT;
        instr_valid = 1'h0;
        @(posedge ref_clk);
        @(negedge ref_clk);
        g = {acc, carry, file_wr.we, stack_pop, pc_load, instr_ready};
        chk(g, {e_acc, e_c, 4'h1});
        $display("test idle done");
    endtask : idle
    task automatic rst_mid();
        logic [27:0] g;
        put(lrr_pkg::LRR_OP_RET_LIT, 8'hA5, 7'h00, 1'h0, 8'h00);
        resetn = 1'h0;
        put(lrr_pkg::LRR_OP_ROT_LEFT, 8'h00, 7'h11, 1'h1, 8'hFF);
        g = {acc, carry, instr_ready, stack_pop, pc_load, file_wr.we,
            pc_value};
        chk(g, {8'h00, 1'h0, 1'h1, 3'h0, 15'h0000});
        resetn = 1'h1;
        e_acc = 8'h00;
        e_c = 1'h0;
        $display("test mid-run reset done");
    endtask : rst_mid
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        chk({acc, carry, instr_ready}, {8'h00, 1'h0, 1'h1});
        resetn = 1'h1;
        e_acc = 8'h00;
        e_c = 1'h0;
        rl(7'h00, 1'h0, 8'hE6);
        rl(7'h7F, 1'h1, 8'h7F);
        ret(8'hFF, 15'h7FFF);
        ret(8'h00, 15'h0001);
        idle();
        rst_mid();
        for (int i = 0; i < 60; i++) begin
            v = rnd();
            if (v[0]) ret(v[15:8], v[30:16]);
            else rl(v[14:8], v[1], v[23:16]);
        end
        instr_valid = 1'h0;
        end_of_test();
    end
endmodule : lrr_exec_tb_top
